//--- rtl/ersq_map.svh
`ifndef ERSQ_MAP_SVH
`define ERSQ_MAP_SVH

// Register byte addresses
`define ERSQ_REG_CTRL    5'h00
`define ERSQ_REG_STEP    5'h04
`define ERSQ_REG_WIN_LO  5'h08
`define ERSQ_REG_WIN_HI  5'h0c
`define ERSQ_REG_COUNT   5'h10
`define ERSQ_REG_STATUS  5'h14

// Control word fields
`define ERSQ_C_SRC_SEL   0
`define ERSQ_C_EXP_LO    1
`define ERSQ_C_EXP_HI    3
`define ERSQ_C_DEN_LO    4
`define ERSQ_C_DEN_HI    13
`define ERSQ_C_HOLD_LOW  14
`define ERSQ_C_FREE_RUN  15
`define ERSQ_C_MCLK_SEL  16
`define ERSQ_C_EDGE_RES  17
`define ERSQ_C_DIR_LO    18
`define ERSQ_C_DIR_HI    19
`define ERSQ_C_WIN_EN    20
`define ERSQ_C_SINGLE    21
`define ERSQ_C_STEP_EN   22
`define ERSQ_C_SIMPLE    23
`define ERSQ_C_ROUTE     24
`define ERSQ_C_CLEAR     31

// Reset value and exponent clamp limit
`define ERSQ_CTRL_RST    31'h0000_0010
`define ERSQ_EXP_MAX     3'h6

// Capture direction codes
`define ERSQ_DIR_BOTH    2'h0
`define ERSQ_DIR_POS     2'h1
`define ERSQ_DIR_NEG     2'h2

// Timing: core clock and slowest input the scaler tracks
`define ERSQ_CLK_KHZ     40000
`define ERSQ_MIN_FIN_HZ  1600
`define ERSQ_SLOW_CYC    ((`ERSQ_CLK_KHZ * 1000) / `ERSQ_MIN_FIN_HZ)

`endif

//--- rtl/ersq_pkg.sv
package ersq_pkg;

  // Scaler modes, one-hot
  typedef enum logic [1:0] {
    SC_TRACK = 2'b01,
    SC_SLOW  = 2'b10
  } ersq_sc_t;

  typedef struct packed {
    logic [30:0] ctrl;
    logic [15:0] step_n;
    logic [23:0] win_lo;
    logic [23:0] win_hi;
    logic [2:0]  ph_a;
    logic [2:0]  ph_b;
    logic [23:0] pos;
    logic [23:0] hi_mark;
    logic [23:0] lo_mark;
    logic        dir;
    logic        fresh;
    logic [15:0] step_cnt;
    ersq_sc_t    sc;
    logic        src_d;
    logic [15:0] per_cnt;
    logic [15:0] per;
    logic [9:0]  lock_cnt;
    logic [11:0] slow_cnt;
    logic [25:0] out_cnt;
    logic        wait_n;
    logic [31:0] rdata;
    logic        line;
    logic        frame;
    logic        scal;
    logic        trig;
  } ersq_state_t;

endpackage

//--- rtl/ersq_top.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ersq_map.svh"

module ersq_top #(
  parameter logic [15:0] SLOW_CYCLES = 16'(`ERSQ_SLOW_CYC)
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        enc_phase_a,
  input  wire logic        enc_phase_b,
  output var  logic        line_trigger,
  output var  logic        frame_trigger,
  output var  logic        scaler_pulse,
  output var  logic        encoder_trigger
);
  import ersq_pkg::*;

  ersq_state_t st_q;
  ersq_state_t st_d;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Control fields
  logic        src_sel;
  logic [2:0]  exp_eff;
  logic [9:0]  den_eff;
  logic        hold_low;
  logic        free_run;
  logic        edge_res;
  logic [1:0]  cap_dir;
  logic        win_en;
  logic        single;
  logic        step_en;
  logic        simple;
  logic        route;

  always_comb begin
    src_sel  = st_q.ctrl[`ERSQ_C_SRC_SEL];
    exp_eff  = st_q.ctrl[`ERSQ_C_EXP_HI:`ERSQ_C_EXP_LO];
    if (exp_eff > `ERSQ_EXP_MAX) begin
      exp_eff = `ERSQ_EXP_MAX;
    end
    den_eff  = st_q.ctrl[`ERSQ_C_DEN_HI:`ERSQ_C_DEN_LO];
    if (den_eff == 10'h000) begin
      den_eff = 10'h001;
    end
    hold_low = st_q.ctrl[`ERSQ_C_HOLD_LOW];
    free_run = st_q.ctrl[`ERSQ_C_FREE_RUN];
    edge_res = st_q.ctrl[`ERSQ_C_EDGE_RES];
    cap_dir  = st_q.ctrl[`ERSQ_C_DIR_HI:`ERSQ_C_DIR_LO];
    win_en   = st_q.ctrl[`ERSQ_C_WIN_EN];
    single   = st_q.ctrl[`ERSQ_C_SINGLE];
    step_en  = st_q.ctrl[`ERSQ_C_STEP_EN];
    simple   = st_q.ctrl[`ERSQ_C_SIMPLE];
    route    = st_q.ctrl[`ERSQ_C_ROUTE];
  end

  // Quadrature decode on the synchronised phases
  logic        a_s;
  logic        a_o;
  logic        b_s;
  logic        b_o;
  logic        chg_a;
  logic        chg_b;
  logic        step;
  logic        up;
  logic [23:0] nxt;
  logic        dir_ok;
  logic        win_ok;
  logic        new_ok;
  logic        line;
  logic        in_win;

  always_comb begin
    a_s   = st_q.ph_a[1];
    a_o   = st_q.ph_a[2];
    b_s   = st_q.ph_b[1];
    b_o   = st_q.ph_b[2];
    chg_a = a_s ^ a_o;
    chg_b = b_s ^ b_o;
    // Both phases moving at once is illegal; ignored with edge_res, but without it one rising as the other falls still counts
    if (edge_res) begin
      step = chg_a ^ chg_b;
    end else begin
      step = (a_s & ~a_o) ^ (b_s & ~b_o);
    end
    up  = chg_a ? (a_s ^ b_o) : ~(b_s ^ a_o);
    nxt = up ? st_q.pos + 24'h1 : st_q.pos - 24'h1;
    unique case (cap_dir)
      `ERSQ_DIR_BOTH: dir_ok = 1'b1;
      `ERSQ_DIR_POS:  dir_ok = up;
      `ERSQ_DIR_NEG:  dir_ok = ~up;
      default:        dir_ok = 1'b0;
    endcase
    dir_ok = dir_ok | simple;
    win_ok = ~win_en |
             ((nxt >= st_q.win_lo) && (nxt <= st_q.win_hi));
    // Only positions beyond anything reached before count as new
    new_ok = ~single |
             (up ? (nxt > st_q.hi_mark) : (nxt < st_q.lo_mark));
    line   = step & dir_ok & win_ok & new_ok;
    in_win = (st_q.pos >= st_q.win_lo) && (st_q.pos <= st_q.win_hi);
  end

  // Rate scaler arithmetic
  logic        src;
  logic        src_edge;
  logic [25:0] prod;
  logic [25:0] target;
  logic        slow_now;

  always_comb begin
    src      = src_sel ? st_q.line : a_s;
    src_edge = src & ~st_q.src_d;
    prod     = 26'(st_q.per) * 26'(den_eff);
    target   = prod >> exp_eff;
    slow_now = st_q.per_cnt >= SLOW_CYCLES;
  end

  // Bus decode
  logic        acc;
  logic        wr;
  logic        clear;
  logic [31:0] rd_mux;

  always_comb begin
    acc   = (avs_read | avs_write) & st_q.wait_n;
    wr    = avs_write & ~st_q.wait_n;
    clear = wr && avs_address == `ERSQ_REG_CTRL &&
            avs_byteenable[3] && avs_writedata[`ERSQ_C_CLEAR];
    unique case (avs_address)
      `ERSQ_REG_CTRL:   rd_mux = {1'b0, st_q.ctrl};
      `ERSQ_REG_STEP:   rd_mux = {16'h0000, st_q.step_n};
      `ERSQ_REG_WIN_LO: rd_mux = {8'h00, st_q.win_lo};
      `ERSQ_REG_WIN_HI: rd_mux = {8'h00, st_q.win_hi};
      `ERSQ_REG_COUNT:  rd_mux = {8'h00, st_q.pos};
      `ERSQ_REG_STATUS: rd_mux = {26'h0, st_q.sc == SC_SLOW,
                                  st_q.fresh, in_win, st_q.dir,
                                  b_s, a_s};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    st_d = st_q;
    st_d.line  = 1'b0;
    st_d.frame = 1'b0;
    st_d.scal  = 1'b0;

    // Two-stage synchronisers, third stage for edges
    st_d.ph_a = {st_q.ph_a[1:0], enc_phase_a};
    st_d.ph_b = {st_q.ph_b[1:0], enc_phase_b};

    // Position system
    if (step) begin
      st_d.pos = nxt;
      st_d.dir = up;
      if (up && nxt > st_q.hi_mark) begin
        st_d.hi_mark = nxt;
      end
      if (!up && nxt < st_q.lo_mark) begin
        st_d.lo_mark = nxt;
      end
    end
    if (line) begin
      st_d.line  = 1'b1;
      st_d.fresh = 1'b1;
    end
    // Step counting only while enabled, so no stray frames otherwise
    if (line && step_en) begin
      if (st_q.step_n != 16'h0000 &&
          st_q.step_cnt + 16'h1 >= st_q.step_n) begin
        st_d.step_cnt = 16'h0000;
        st_d.frame    = 1'b1;
      end else begin
        st_d.step_cnt = st_q.step_cnt + 16'h1;
      end
    end

    // Scaler: period measurement saturates at the slow limit
    st_d.src_d = src;
    if (src_edge) begin
      st_d.per     = st_q.per_cnt + 16'h1;
      st_d.per_cnt = 16'h0000;
    end else if (!slow_now) begin
      st_d.per_cnt = st_q.per_cnt + 16'h1;
    end

    unique case (st_q.sc)
      SC_TRACK: begin
        if (st_q.out_cnt + 26'h1 >= target) begin
          st_d.out_cnt = 26'h0;
          st_d.scal    = 1'b1;
        end else begin
          st_d.out_cnt = st_q.out_cnt + 26'h1;
        end
        // With free_run clear, every den input edges span exactly 2^exp outputs when per times den is a multiple of 2^exp
        if (src_edge) begin
          if (st_q.lock_cnt + 10'h1 >= den_eff) begin
            st_d.lock_cnt = 10'h000;
            if (!free_run) begin
              st_d.out_cnt = 26'h0;
              st_d.scal    = 1'b1;
            end
          end else begin
            st_d.lock_cnt = st_q.lock_cnt + 10'h1;
          end
        end
        if (slow_now) begin
          st_d.sc       = SC_SLOW;
          st_d.slow_cnt = 12'h000;
          st_d.scal     = 1'b0;
        end
      end
      SC_SLOW: begin
        if (src_edge) begin
          // Plain divide by four times den while the loop cannot track
          if (st_q.slow_cnt + 12'h1 >= {den_eff, 2'b00}) begin
            st_d.slow_cnt = 12'h000;
            st_d.scal     = ~hold_low;
          end else begin
            st_d.slow_cnt = st_q.slow_cnt + 12'h1;
          end
          if (st_q.per_cnt < SLOW_CYCLES) begin
            st_d.sc       = SC_TRACK;
            st_d.out_cnt  = 26'h0;
            st_d.lock_cnt = 10'h000;
          end
        end
      end
      default: begin
        st_d.sc = SC_TRACK;
      end
    endcase

    // Trigger routing to the consumers
    if (step_en) begin
      st_d.trig = st_d.frame;
    end else if (route) begin
      st_d.trig = st_d.scal;
    end else begin
      st_d.trig = st_d.line;
    end

    // Avalon slave: one wait cycle, then the access completes
    st_d.wait_n = 1'b1;
    if (acc) begin
      st_d.wait_n = 1'b0;
      st_d.rdata  = rd_mux;
    end
    if (wr) begin
      unique case (avs_address)
        `ERSQ_REG_CTRL: begin
          // Master clock select is stored but only zero is meaningful
          st_d.ctrl = 31'(merge({1'b0, st_q.ctrl}, avs_writedata,
                                avs_byteenable));
        end
        `ERSQ_REG_STEP: begin
          st_d.step_n = 16'(merge({16'h0000, st_q.step_n},
                                  avs_writedata, avs_byteenable));
        end
        `ERSQ_REG_WIN_LO: begin
          st_d.win_lo = 24'(merge({8'h00, st_q.win_lo},
                                  avs_writedata, avs_byteenable));
        end
        `ERSQ_REG_WIN_HI: begin
          st_d.win_hi = 24'(merge({8'h00, st_q.win_hi},
                                  avs_writedata, avs_byteenable));
        end
        default: begin
        end
      endcase
    end
    // Status read clears fresh flag; a new line the same cycle wins
    if (wr == 1'b0 && avs_read && !st_q.wait_n &&
        avs_address == `ERSQ_REG_STATUS && !line) begin
      st_d.fresh = 1'b0;
    end

    // Clear has priority over any movement in the same cycle
    if (clear) begin
      st_d.pos      = 24'h0;
      st_d.hi_mark  = 24'h0;
      st_d.lo_mark  = 24'h0;
      st_d.dir      = 1'b0;
      st_d.fresh    = 1'b0;
      st_d.step_cnt = 16'h0000;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q          <= '0;
      st_q.ctrl     <= `ERSQ_CTRL_RST;
      // No input period measured yet, so the output starts static
      st_q.sc       <= SC_SLOW;
      st_q.wait_n   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  always_comb begin
    avs_readdata    = st_q.rdata;
    avs_waitrequest = st_q.wait_n;
    line_trigger    = st_q.line;
    frame_trigger   = st_q.frame;
    scaler_pulse    = st_q.scal;
    encoder_trigger = st_q.trig;
  end

endmodule

`default_nettype wire

//--- bench/ersq_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Shaft encoder; one quarter step per mv, A leads B going up
module ersq_enc_model (
  input  wire logic core_clk,
  input  wire logic mv,
  input  wire logic up,
  output var  logic pa,
  output var  logic pb
);
  logic [1:0] st_q = 2'h0;
  // Gray walk keeps the phases 90 degrees apart
  always_ff @(posedge core_clk) begin
    if (mv) st_q <= up ? st_q + 2'h1 : st_q - 2'h1;
  end
  assign pa = ^st_q;
  assign pb = st_q[1];
endmodule
`default_nettype wire

//--- bench/ersq_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Bus and trigger timing seen from the pins of the top
module ersq_chk (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        enc_phase_a,
  input wire logic        enc_phase_b,
  input wire logic        line_trigger,
  input wire logic        frame_trigger,
  input wire logic        scaler_pulse,
  input wire logic        encoder_trigger
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [4:0] ha_q, hb_q;
  logic       req;
  assign req = avs_read | avs_write;
  // Phase history; a line may come three or four edges after a change
  always_ff @(posedge core_clk) begin
    ha_q <= {ha_q[3:0], enc_phase_a};
    hb_q <= {hb_q[3:0], enc_phase_b};
  end
  sequence s_pend; req && avs_waitrequest; endsequence
  sequence s_done; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_answer; s_pend |=> s_done; endproperty
  property p_ack; !avs_waitrequest |-> req; endproperty
  property p_rhold; !req |=> $stable(avs_readdata); endproperty
  property p_cause;
    line_trigger |-> (ha_q[3] ^ ha_q[4]) | (hb_q[3] ^ hb_q[4])
      | (ha_q[2] ^ ha_q[3]) | (hb_q[2] ^ hb_q[3]);
  endproperty
  property p_lpulse; line_trigger |=> !line_trigger; endproperty
  property p_fpulse; frame_trigger |=> !frame_trigger; endproperty
  property p_fline; frame_trigger |-> line_trigger; endproperty
  property p_esrc;
    encoder_trigger |-> line_trigger | frame_trigger | scaler_pulse;
  endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  a_ack: assert property (p_ack) else $error("stray ack");
  a_rhold: assert property (p_rhold) else $error("data moved");
  a_cause: assert property (p_cause) else $error("line uncaused");
  a_lpulse: assert property (p_lpulse) else $error("long line");
  a_fpulse: assert property (p_fpulse) else $error("long frame");
  a_fline: assert property (p_fline) else $error("frame alone");
  a_esrc: assert property (p_esrc) else $error("bad source");
endmodule
bind ersq_top ersq_chk u_chk (.core_clk, .rstn, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .enc_phase_a, .enc_phase_b,
  .line_trigger, .frame_trigger, .scaler_pulse, .encoder_trigger);
`default_nettype wire

//--- bench/ersq_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ersq_bench;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        mv = 1'b0;
  logic        up = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [3:0]  ben = 4'hf;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdv, q;
  logic        pa, pb, lt, ft, sp, et, wq;
  logic [23:0] pos, hi, lo;
  logic [1:0]  st = 2'h0;
  int          seed = 38;
  int          err_total = 0;
  int          samples_checked = 0;
  int          nl = 0, nf = 0, ns = 0, ne = 0, xl, xf, sc, i;
  logic [31:0] cfg [9] = '{32'h0002_0000, 32'h0, 32'h0006_0000,
    32'h000a_0000, 32'h000e_0000, 32'h0086_0000, 32'h0016_0000,
    32'h0022_0000, 32'h0076_0000};
  ersq_top #(.SLOW_CYCLES(16'd200)) DUT (.core_clk, .rstn,
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(ben), .avs_readdata(rdv), .avs_waitrequest(wq),
    .enc_phase_a(pa), .enc_phase_b(pb), .line_trigger(lt),
    .frame_trigger(ft), .scaler_pulse(sp), .encoder_trigger(et));
  ersq_enc_model enc (.core_clk, .mv, .up, .pa, .pb);
  initial forever #12.5 core_clk = ~core_clk;
  // Running tallies; scenarios take differences, so none is ever zeroed
  always @(posedge core_clk) begin
    nl = nl + (lt === 1'b1);
    nf = nf + (ft === 1'b1);
    ns = ns + (sp === 1'b1);
    ne = ne + (et === 1'b1);
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    // Only the watchdog ends a wait that never completes
    do @(posedge core_clk); while (wq !== 1'b0);
    r = rdv;
    rd <= 1'b0; wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    cmp(r, e);
  endtask
  function automatic int fexp(int p, logic [31:0] c, bit slow);
    if (slow && c[14]) return 0;
    if (slow) return p / (4 * c[13:4]);
    return p * (1 << c[3:1]) / c[13:4];
  endfunction
  // One quarter step, with the expected line and frame bookkeeping
  task automatic mvs(input logic u, input logic [31:0] c, input int g);
    logic oa, ob, k, ok, nw;
    oa = ^st; ob = st[1];
    st = u ? st + 2'h1 : st - 2'h1;
    k = c[17] | (^st & !oa) | (st[1] & !ob);
    if (k) pos = u ? pos + 24'h1 : pos - 24'h1;
    ok = k & (c[23] | c[19:18] == 2'h0 | c[19:18] == {!u, u});
    ok = ok & (!c[20] | (pos >= 24'h3 & pos <= 24'h8));
    // Reach marks follow every count, acquired or not
    nw = k & (u ? pos > hi : pos < lo);
    if (nw & u) hi = pos;
    if (nw & !u) lo = pos;
    ok = ok & (!c[21] | nw);
    if (ok) xl++;
    if (ok & c[22]) sc++;
    if (sc == 3) begin sc = 0; xf++; end
    mv <= 1'b1; up <= u;
    @(posedge core_clk);
    mv <= 1'b0;
    repeat (g - 1) @(posedge core_clk);
  endtask
  task automatic run(input logic [31:0] c);
    int b1, b2, b3, j;
    wreg(5'h00, 32'h8000_0000);
    wreg(5'h04, 32'h3); wreg(5'h08, 32'h3); wreg(5'h0c, 32'h8);
    wreg(5'h00, c);
    pos = 0; hi = 0; lo = 0; sc = 0; xl = 0; xf = 0;
    b1 = nl; b2 = nf; b3 = ne;
    for (j = 0; j < 40; j++)
      mvs(j < 4 || j > 35 || ($random(seed) & 3) != 0, c, 40);
    repeat (8) @(posedge core_clk);
    cmp(nl - b1, xl);
    cmp(nf - b2, xf);
    cmp(ne - b3, c[22] ? xf : xl);
    chk(5'h10, {8'h0, pos});
    bus(1'b0, 5'h14, 32'h0, q);
    cmp(q[4:0], {xl != 0, pos >= 3 && pos <= 8, 1'b1, st[1], ^st});
    bus(1'b0, 5'h14, 32'h0, q);
    cmp(q[4], 1'b0);
  endtask
  // Scaler on phase A or the line source per c[0], routed to encoder_trigger; warm-up edges ignored
  task automatic scal(input logic [31:0] c, input int g, input int n);
    int b, be, e, t, d;
    wreg(5'h00, c);
    repeat (16) mvs(1'b1, c, g);
    b = ns; be = ne; t = c[14] ? 0 : 2;
    // Line source in 4x mode gives one input edge per quarter step
    e = fexp(c[0] ? n : n / 4, c, g > 50);
    repeat (n) mvs(1'b1, c, g);
    d = ns - b;
    cmp(ne - be, d);
    cmp(d >= e - t && d <= e + t, 1);
    bus(1'b0, 5'h14, 32'h0, q);
    cmp(q[5], g > 50);
  endtask
  initial begin
    #1500000;
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk(5'h00, 32'h10);
    chk(5'h10, 32'h0);
    wreg(5'h10, 32'h00ff_ffff);
    chk(5'h10, 32'h0);
    chk(5'h18, 32'h0);
    ben <= 4'h3;
    wreg(5'h08, 32'h00ab_cdef);
    ben <= 4'hf;
    chk(5'h08, 32'h0000_cdef);
    foreach (cfg[k]) run(cfg[k]);
    for (i = 0; i < 2; i++) scal(32'h0100_0034 | (i << 15), 40, 96);
    for (i = 0; i < 2; i++) scal(32'h0100_0010 | (i << 14), 80, 64);
    scal(32'h0102_0011, 40, 64);
    give_verdict;
  end
endmodule
`default_nettype wire
